// [include/mcis_defs.svh]
// Behaviour
// RL1: two independent external interrupt sources, four selectable pin event sensitivities each
// RL2: bits 4:3 pick port B sense: 00 fall+low, 01 rise, 10 fall, 11 both
// RL3: bits 2:1 pick port A sense with the same encoding
// RL4: sense fields change only on writes while the global interrupt mask is 1
// RL5: software changes sensitivity only with interrupts masked
// RL6: bit 7 picks peripheral clock: 0 osc/2, 1 osc/4
// RL7: software keeps the peripheral clock at or below 4 MHz
// RL8: bit 6 picks slave-select source: 0 pin, 1 internal bit
// RL9: with internal source selected, bit 5 drives the SPI slave-select input
// RL10: internal source frees port B pin 2 for general-purpose use
// RL11: bit 0 picks CPU clock: 0 osc/2, 1 osc/32
// RL12: register is read/write and resets to all zeros
// RL13: fall+low mode requests on falling edge and stays while pin low
`ifndef MCIS_DEFS_SVH
`define MCIS_DEFS_SVH
// ****************************************
// register map
// ****************************************
`define MCIS_MISC_CONTROL_OFS 12'h020
`define MCIS_IRQ_STATUS_OFS 12'h024
`define MCIS_IRQ_MASK_OFS 12'h028
`define MCIS_MISC_CONTROL_RST 8'h00
// ****************************************
// field positions
// ****************************************
`define MCIS_PERIPH_DIV_BIT 7
`define MCIS_SS_SRC_BIT 6
`define MCIS_SS_INT_BIT 5
`define MCIS_PB_SENSE_HI 4
`define MCIS_PB_SENSE_LO 3
`define MCIS_PA_SENSE_HI 2
`define MCIS_PA_SENSE_LO 1
`define MCIS_SLOW_CPU_BIT 0
// ****************************************
// clock divider counts
// ****************************************
`define MCIS_DIV_NORMAL 2
`define MCIS_DIV_PERIPH_SLOW 4
`define MCIS_DIV_CPU_SLOW 32
`endif

// [include/mcis_pkg.sv]
package mcis_pkg;
    // sensitivity encoding of one external interrupt source
    typedef enum logic [1:0] {
        MCIS_FALL_LOW = 2'h0,
        MCIS_RISE = 2'h1,
        MCIS_FALL = 2'h2,
        MCIS_BOTH = 2'h3
    } mcis_sense_e;

    // apb answer phase, one-hot
    typedef enum logic [1:0] {
        MCIS_IDLE = 2'b01,
        MCIS_DONE = 2'b10
    } mcis_state_e;

    typedef struct packed {
        mcis_state_e st;
        logic [7:0] ctrl;
        logic [1:0] irq_sts;
        logic [1:0] irq_msk;
        logic [1:0] pa_sync;
        logic [1:0] pb_sync;
        logic [1:0] ss_sync;
        logic pa_prev;
        logic pb_prev;
        logic [4:0] div_cnt;
        logic periph_clk;
        logic cpu_clk;
        logic pa_req;
        logic pb_req;
        logic ss_level;
        logic pb2_free;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } mcis_state_s;
endpackage : mcis_pkg

// [rtl/mcis_misc_ctrl.sv]
`timescale 1ns/1ns
`include "mcis_defs.svh"
module mcis_misc_ctrl (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu state
    input wire logic global_irq_mask,
    // external pins, asynchronous
    input wire logic port_a_ext_irq,
    input wire logic port_b_ext_irq,
    input wire logic spi_ss_pin_n,
    // derived controls
    output logic port_a_irq_req,
    output logic port_b_irq_req,
    output logic spi_ss_n,
    output logic port_b_pin2_free,
    output logic periph_clk,
    output logic cpu_clk,
    output logic irq
);
    mcis_pkg::mcis_state_s s_q, s_d;

    // ****************************************
    // request of one source from its sense mode
    // ****************************************
    function automatic logic sense_req(input logic [1:0] mode, input logic cur,
                                       input logic prev);
        logic fall;
        logic rise;
        fall = prev & ~cur;
        rise = ~prev & cur;
        // mode 00 keeps requesting for as long as the pin stays low
        case (mode)
            2'h0: sense_req = fall | ~cur; // RL13
            2'h1: sense_req = rise; // RL2
            2'h2: sense_req = fall; // RL2
            default: sense_req = fall | rise; // RL2
        endcase
    endfunction : sense_req

    logic acc;
    logic wr;
    logic [31:0] rd;
    logic pa_new;
    logic pb_new;
    logic [4:0] half;
    always_comb begin
        s_d = s_q;
        acc = psel & penable & (s_q.st == mcis_pkg::MCIS_IDLE);
        wr = acc & pwrite;
        rd = 32'h0000_0000;
        pa_new = 1'b0;
        pb_new = 1'b0;
        half = 5'h00;
        // synchronisers: first stage read only by the second
        // pins are asynchronous, so stage one may still be settling
        s_d.pa_sync = {s_q.pa_sync[0], port_a_ext_irq};
        s_d.pb_sync = {s_q.pb_sync[0], port_b_ext_irq};
        s_d.ss_sync = {s_q.ss_sync[0], spi_ss_pin_n};
        s_d.pa_prev = s_q.pa_sync[1];
        s_d.pb_prev = s_q.pb_sync[1];
        // two independent detectors
        pa_new = sense_req(s_q.ctrl[`MCIS_PA_SENSE_HI:`MCIS_PA_SENSE_LO],
                           s_q.pa_sync[1], s_q.pa_prev); // RL1 RL3
        pb_new = sense_req(s_q.ctrl[`MCIS_PB_SENSE_HI:`MCIS_PB_SENSE_LO],
                           s_q.pb_sync[1], s_q.pb_prev); // RL1 RL2
        s_d.pa_req = pa_new;
        s_d.pb_req = pb_new;
        // slave-select source mux and pin release
        s_d.ss_level = s_q.ctrl[`MCIS_SS_SRC_BIT] ? s_q.ctrl[`MCIS_SS_INT_BIT]
                                                  : s_q.ss_sync[1]; // RL8 RL9
        s_d.pb2_free = s_q.ctrl[`MCIS_SS_SRC_BIT]; // RL10
        // shared divider: half periods of 1, 2 or 16 pclk cycles
        // a mode change mid-count may shorten one period; accepted for one counter
        s_d.div_cnt = s_q.div_cnt + 5'h01;
        half = s_q.ctrl[`MCIS_SLOW_CPU_BIT] ? 5'(`MCIS_DIV_CPU_SLOW / 2)
                                            : 5'(`MCIS_DIV_NORMAL / 2);
        if (s_q.div_cnt[3:0] == 4'((half - 5'h01) & 5'h0f) || half == 5'h01) begin
            s_d.cpu_clk = ~s_q.cpu_clk; // RL11
        end
        if (s_q.ctrl[`MCIS_PERIPH_DIV_BIT]) begin
            if (s_q.div_cnt[0]) begin
                s_d.periph_clk = ~s_q.periph_clk; // RL6
            end
        end else begin
            s_d.periph_clk = ~s_q.periph_clk; // RL6
        end
        if (s_q.ctrl[`MCIS_SLOW_CPU_BIT] && s_q.div_cnt[3:0] == 4'hf) begin
            s_d.div_cnt = 5'h00;
        end
        // apb read mux
        case (paddr)
            `MCIS_MISC_CONTROL_OFS: rd = {24'h00_0000, s_q.ctrl}; // RL12
            `MCIS_IRQ_STATUS_OFS: rd = {30'h0000_0000, s_q.irq_sts};
            `MCIS_IRQ_MASK_OFS: rd = {30'h0000_0000, s_q.irq_msk};
            default: rd = 32'h0000_0000;
        endcase
        // sticky status; a new event beats a write-one clear
        if (wr && paddr == `MCIS_IRQ_STATUS_OFS) begin
            s_d.irq_sts = s_q.irq_sts & ~pwdata[1:0];
        end
        s_d.irq_sts = s_d.irq_sts | {pb_new, pa_new};
        // sense bits held unless the cpu has masked interrupts
        if (wr && paddr == `MCIS_MISC_CONTROL_OFS) begin
            s_d.ctrl[7:5] = pwdata[7:5]; // RL12
            s_d.ctrl[0] = pwdata[0]; // RL12
            if (global_irq_mask) begin
                s_d.ctrl[4:1] = pwdata[4:1]; // RL4
            end
        end
        if (wr && paddr == `MCIS_IRQ_MASK_OFS) begin
            s_d.irq_msk = pwdata[1:0];
        end
        // level irq from the next status, so it rises with the bit
        s_d.irq = |(s_d.irq_sts & s_d.irq_msk);
        // one wait state then answer
        case (s_q.st)
            mcis_pkg::MCIS_IDLE: begin
                s_d.pready = 1'b0;
                if (acc) begin
                    s_d.st = mcis_pkg::MCIS_DONE;
                    s_d.pready = 1'b1;
                    s_d.prdata = pwrite ? 32'h0000_0000 : rd;
                    s_d.pslverr = ~(paddr == `MCIS_MISC_CONTROL_OFS ||
                                    paddr == `MCIS_IRQ_STATUS_OFS ||
                                    paddr == `MCIS_IRQ_MASK_OFS);
                end
            end
            mcis_pkg::MCIS_DONE: begin
                s_d.st = mcis_pkg::MCIS_IDLE;
                s_d.pready = 1'b0;
                s_d.pslverr = 1'b0;
            end
            default: s_d.st = mcis_pkg::MCIS_IDLE;
        endcase
    end

    // ****************************************
    // single state register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.st <= mcis_pkg::MCIS_IDLE;
            s_q.ctrl <= `MCIS_MISC_CONTROL_RST; // RL12
            s_q.pa_sync <= 2'h3;
            s_q.pb_sync <= 2'h3;
            s_q.ss_sync <= 2'h3;
            s_q.pa_prev <= 1'b1;
            s_q.pb_prev <= 1'b1;
            s_q.ss_level <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flops
    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign port_a_irq_req = s_q.pa_req;
    assign port_b_irq_req = s_q.pb_req;
    assign spi_ss_n = s_q.ss_level;
    assign port_b_pin2_free = s_q.pb2_free;
    assign periph_clk = s_q.periph_clk;
    assign cpu_clk = s_q.cpu_clk;
    assign irq = s_q.irq;

    // ****************************************
    // checks
    // ****************************************
    // all checks run on pclk and sleep through reset
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_sense_write_lock: assert property ( // RL4
        (psel && penable && !pready && pwrite && paddr == `MCIS_MISC_CONTROL_OFS
         && !global_irq_mask) |=> $stable(s_q.ctrl[4:1]))
        else $error("sense field changed while unmasked");
    a_sense_write_ok: assert property ( // RL4
        (psel && penable && !pready && pwrite && paddr == `MCIS_MISC_CONTROL_OFS
         && global_irq_mask) |=> s_q.ctrl == $past(pwdata[7:0]))
        else $error("control write lost");
    a_ss_internal: assert property ( // RL9
        s_q.ctrl[`MCIS_SS_SRC_BIT] |=> spi_ss_n == $past(s_q.ctrl[`MCIS_SS_INT_BIT]))
        else $error("internal slave select not routed");
    a_ss_pin: assert property ( // RL8
        !s_q.ctrl[`MCIS_SS_SRC_BIT] |=> spi_ss_n == $past(s_q.ss_sync[1]))
        else $error("pin slave select not routed");
    a_pin2_free: assert property ( // RL10
        ##1 port_b_pin2_free == $past(s_q.ctrl[`MCIS_SS_SRC_BIT]))
        else $error("pin release wrong");
    a_fall_low_hold: assert property ( // RL13
        (s_q.ctrl[2:1] == 2'h0 && !s_q.pa_sync[1]) |=> port_a_irq_req)
        else $error("low level not held as request");
    a_rise_only: assert property ( // RL2
        (s_q.ctrl[4:3] == 2'h1 && !s_q.pb_prev && s_q.pb_sync[1]) |=> port_b_irq_req)
        else $error("rising edge missed");
    a_fall_no_rise: assert property ( // RL3
        (s_q.ctrl[2:1] == 2'h2 && !s_q.pa_prev && s_q.pa_sync[1]) |=> !port_a_irq_req)
        else $error("rise in fall-only mode");
    a_periph_fast: assert property ( // RL6
        (!s_q.ctrl[7] && $stable(s_q.ctrl[7])) |=> periph_clk != $past(periph_clk))
        else $error("periph clock not osc/2");
    a_apb_answer: assert property (
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("apb answer not one cycle");

    // ****************************************
    // clock divider checks
    // ****************************************
    a_cpu_fast: assert property ( // RL11
        !s_q.ctrl[`MCIS_SLOW_CPU_BIT] |=> cpu_clk != $past(cpu_clk))
        else $error("cpu clock not osc/2");
    // slow mode flips only where the shared count wraps
    a_cpu_slow_wait: assert property ( // RL11
        (s_q.ctrl[`MCIS_SLOW_CPU_BIT] && s_q.div_cnt[3:0] != 4'hf) |=> $stable(cpu_clk))
        else $error("cpu clock flipped early in slow mode");
    a_cpu_slow_flip: assert property ( // RL11
        (s_q.ctrl[`MCIS_SLOW_CPU_BIT] && s_q.div_cnt[3:0] == 4'hf)
        |=> cpu_clk != $past(cpu_clk))
        else $error("cpu clock missed its slow flip");
    a_periph_hold: assert property ( // RL6
        (s_q.ctrl[`MCIS_PERIPH_DIV_BIT] && !s_q.div_cnt[0]) |=> $stable(periph_clk))
        else $error("periph clock flipped early at osc/4");
    a_periph_slow: assert property ( // RL6
        (s_q.ctrl[`MCIS_PERIPH_DIV_BIT] && s_q.div_cnt[0])
        |=> periph_clk != $past(periph_clk))
        else $error("periph clock not osc/4");

    // ****************************************
    // interrupt checks
    // ****************************************
    a_pa_rise_only: assert property ( // RL3
        (s_q.ctrl[2:1] == 2'h1 && !s_q.pa_prev && s_q.pa_sync[1]) |=> port_a_irq_req)
        else $error("port a rising edge missed");
    a_pa_fall_only: assert property ( // RL3
        (s_q.ctrl[2:1] == 2'h2 && s_q.pa_prev && !s_q.pa_sync[1]) |=> port_a_irq_req)
        else $error("port a falling edge missed");
    a_pb_fall_only: assert property ( // RL2
        (s_q.ctrl[4:3] == 2'h2 && s_q.pb_prev && !s_q.pb_sync[1]) |=> port_b_irq_req)
        else $error("port b falling edge missed");
    a_pb_no_fall: assert property ( // RL2
        (s_q.ctrl[4:3] == 2'h1 && s_q.pb_prev && !s_q.pb_sync[1]) |=> !port_b_irq_req)
        else $error("fall in rise-only mode");
    a_pb_fall_low: assert property ( // RL13
        (s_q.ctrl[4:3] == 2'h0 && !s_q.pb_sync[1]) |=> port_b_irq_req)
        else $error("port b low level not held as request");
    a_pa_both: assert property ( // RL3
        (s_q.ctrl[2:1] == 2'h3 && s_q.pa_prev != s_q.pa_sync[1]) |=> port_a_irq_req)
        else $error("port a edge missed in both-edge mode");
    a_pb_both: assert property ( // RL2
        (s_q.ctrl[4:3] == 2'h3 && s_q.pb_prev != s_q.pb_sync[1]) |=> port_b_irq_req)
        else $error("port b edge missed in both-edge mode");
    // a steady pin must stay quiet in every edge-only mode
    a_pa_quiet: assert property ( // RL3
        (s_q.ctrl[2:1] != 2'h0 && s_q.pa_prev == s_q.pa_sync[1]) |=> !port_a_irq_req)
        else $error("port a request without an edge");
    a_pb_quiet: assert property ( // RL2
        (s_q.ctrl[4:3] != 2'h0 && s_q.pb_prev == s_q.pb_sync[1]) |=> !port_b_irq_req)
        else $error("port b request without an edge");
    // every request leaves its sticky bit set, even under a clear
    a_pa_sticky: assert property ( // RL1
        port_a_irq_req |-> s_q.irq_sts[0])
        else $error("port a request not recorded");
    a_pb_sticky: assert property ( // RL1
        port_b_irq_req |-> s_q.irq_sts[1])
        else $error("port b request not recorded");
    a_irq_level: assert property (
        irq == |(s_q.irq_sts & s_q.irq_msk))
        else $error("irq does not follow unmasked status");

    // ****************************************
    // register access checks
    // ****************************************
    a_ctrl_rest_write: assert property ( // RL12
        (psel && penable && !pready && pwrite && paddr == `MCIS_MISC_CONTROL_OFS)
        |=> {s_q.ctrl[7:5], s_q.ctrl[0]} == {$past(pwdata[7:5]), $past(pwdata[0])})
        else $error("control bits outside the sense fields not written");
    a_ctrl_read: assert property ( // RL12
        (psel && penable && !pready && !pwrite && paddr == `MCIS_MISC_CONTROL_OFS)
        |=> prdata == {24'h00_0000, $past(s_q.ctrl)})
        else $error("control read data wrong");
    a_mask_write: assert property (
        (psel && penable && !pready && pwrite && paddr == `MCIS_IRQ_MASK_OFS)
        |=> s_q.irq_msk == $past(pwdata[1:0]))
        else $error("mask write lost");
    // unmapped offsets answer with an error and change nothing
    a_bad_addr: assert property (
        (psel && penable && !pready && paddr != `MCIS_MISC_CONTROL_OFS
         && paddr != `MCIS_IRQ_STATUS_OFS && paddr != `MCIS_IRQ_MASK_OFS)
        |=> pslverr && $stable(s_q.ctrl))
        else $error("unmapped access not refused");
    c_sense_write: cover property (pready && s_q.ctrl[4:1] != 4'h0);
    c_ss_internal: cover property (s_q.ctrl[6] && spi_ss_n == 1'b0);
    c_slow_cpu: cover property (s_q.ctrl[0] && $rose(cpu_clk));
    c_irq: cover property ($rose(irq));
    c_fall_low_req: cover property (s_q.ctrl[2:1] == 2'h0 && port_a_irq_req);
endmodule : mcis_misc_ctrl

// [verification/tb.sv]
`timescale 1ns/1ns
`include "mcis_defs.svh"
module tb;
    // ****************************************
    // stimulus and observed signals
    // ****************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic global_irq_mask = 1'b0;
    logic pin_a = 1'b1;
    logic pin_b = 1'b1;
    logic ss_pin_n = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, req_a, req_b, spi_ss_n, pb2_free, periph_clk, cpu_clk, irq;
    logic [31:0] rd;
    logic er;
    int num_errors = 0;
    int total_checks = 0;
    int cyc = 0;
    // pins idle high, so a fall then a rise hits every sense mode
    logic [1:0] fall_exp [4] = '{2'h3, 2'h0, 2'h3, 2'h3};
    logic [1:0] rise_exp [4] = '{2'h3, 2'h3, 2'h0, 2'h3};

    mcis_misc_ctrl u_mcis_misc_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .global_irq_mask(global_irq_mask),
        .port_a_ext_irq(pin_a), .port_b_ext_irq(pin_b), .spi_ss_pin_n(ss_pin_n),
        .port_a_irq_req(req_a), .port_b_irq_req(req_b), .spi_ss_n(spi_ss_n),
        .port_b_pin2_free(pb2_free), .periph_clk(periph_clk), .cpu_clk(cpu_clk),
        .irq(irq)
    );

    // ****************************************
    // clock, timeout and verdict
    // ****************************************
    initial begin
        forever #50 pclk = ~pclk;
    end

    task automatic report_and_stop();
        $display("errors %0d of %0d checks", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    // a hang anywhere ends here as one counted mismatch
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // ****************************************
    // apb master and helpers
    // ****************************************
    // request held until pready is sampled high; answer taken at that edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check(n < 20, 1'b1);
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask : rd_chk

    // settle first so a divider change mid-count cannot add a short period
    task automatic clk_chk(input int np_exp, input int nc_exp);
        logic lp, lc;
        int np, nc;
        np = 0;
        nc = 0;
        repeat (40) @(posedge pclk);
        lp = periph_clk;
        lc = cpu_clk;
        repeat (64) begin
            @(posedge pclk);
            np += (periph_clk !== lp);
            nc += (cpu_clk !== lc);
            lp = periph_clk;
            lc = cpu_clk;
        end
        check(np, np_exp);
        check(nc, nc_exp);
    endtask : clk_chk

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`MCIS_MISC_CONTROL_OFS, 32'h0000_0000);
        check({spi_ss_n, pb2_free}, 2'h2);
        clk_chk(64, 64);
        apb(1'b1, `MCIS_MISC_CONTROL_OFS, 32'h0000_00ff);
        rd_chk(`MCIS_MISC_CONTROL_OFS, 32'h0000_00e1);
        global_irq_mask <= 1'b1;
        apb(1'b1, `MCIS_MISC_CONTROL_OFS, 32'h0000_0081);
        rd_chk(`MCIS_MISC_CONTROL_OFS, 32'h0000_0081);
        clk_chk(32, 4);
        // internal source low, then high, while the pin is held low
        apb(1'b1, `MCIS_MISC_CONTROL_OFS, 32'h0000_00c0);
        ss_pin_n <= 1'b0;
        repeat (6) @(posedge pclk);
        check({spi_ss_n, pb2_free}, 2'h1);
        apb(1'b1, `MCIS_MISC_CONTROL_OFS, 32'h0000_00e0);
        repeat (3) @(posedge pclk);
        check({spi_ss_n, pb2_free}, 2'h3);
        apb(1'b1, `MCIS_MISC_CONTROL_OFS, 32'h0000_0080);
        repeat (3) @(posedge pclk);
        check({spi_ss_n, pb2_free}, 2'h0);
        ss_pin_n <= 1'b1;
        apb(1'b0, 12'h030, 32'h0000_0000);
        check(er, 1'b1);
        check(rd, 32'h0000_0000);
        // only port b unmasked, so a set port a bit must not raise irq
        apb(1'b1, `MCIS_IRQ_MASK_OFS, 32'h0000_0002);
        rd_chk(`MCIS_IRQ_MASK_OFS, 32'h0000_0002);
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, `MCIS_MISC_CONTROL_OFS, 32'h0000_0080 | 32'(m * 10));
            apb(1'b1, `MCIS_IRQ_STATUS_OFS, 32'h0000_0003);
            pin_a <= 1'b0;
            pin_b <= 1'b0;
            repeat (8) @(posedge pclk);
            rd_chk(`MCIS_IRQ_STATUS_OFS, 32'(fall_exp[m]));
            check(irq, fall_exp[m][1]);
            check({req_b, req_a}, (m == 0) ? 32'h0000_0003 : 32'h0000_0000);
            apb(1'b1, `MCIS_IRQ_STATUS_OFS, 32'h0000_0003);
            rd_chk(`MCIS_IRQ_STATUS_OFS, (m == 0) ? 32'h0000_0003 : 32'h0000_0000);
            pin_a <= 1'b1;
            pin_b <= 1'b1;
            repeat (8) @(posedge pclk);
            rd_chk(`MCIS_IRQ_STATUS_OFS, 32'(rise_exp[m]));
            check({req_b, req_a}, 32'h0000_0000);
            apb(1'b1, `MCIS_IRQ_STATUS_OFS, 32'h0000_0003);
            rd_chk(`MCIS_IRQ_STATUS_OFS, 32'h0000_0000);
            check(irq, 1'b0);
        end
        report_and_stop();
    end
endmodule : tb
